// ### hdl/pcs_cfg_params.svh
/*
 Constants for the 100 Mb/s PCS configuration register: offset, field positions,
 reset value and timeout counts. Assumes a 100 MHz management clock.
*/
`ifndef PCS_CFG_PARAMS_SVH
`define PCS_CFG_PARAMS_SVH

`define PCS_CFG_ADDR 5'h16
`define PCS_CFG_RESET 16'h0100
`define PCS_CFG_WRITE_MASK 16'h07A4
`define PCS_CFG_RESERVED_HI_MASK 16'hE000
`define PCS_CFG_MUST_ZERO_MASK 16'h185B
`define PCS_CFG_BIT_TRUE_QUIET 10
`define PCS_CFG_BIT_SD_FORCE 9
`define PCS_CFG_BIT_SD_ALGO 8
`define PCS_CFG_BIT_DESCRAMBLER_TIMEOUT_SELECT 7
`define PCS_CFG_BIT_FORCE_LINK 5
`define PCS_CFG_BIT_NRZI_BYPASS 2
`define PCS_CLK_PERIOD_NS 10
`define PCS_DESC_TIMEOUT_LONG_US 2000
`define PCS_DESC_TIMEOUT_SHORT_US 722
`define PCS_DESC_LONG_CYCLES ((`PCS_DESC_TIMEOUT_LONG_US * 1000) / `PCS_CLK_PERIOD_NS)
`define PCS_DESC_SHORT_CYCLES ((`PCS_DESC_TIMEOUT_SHORT_US * 1000) / `PCS_CLK_PERIOD_NS)

`endif

// ### hdl/pcs_cfg_pkg.sv
/*
 Types for the 100 Mb/s PCS configuration register.
 Assumes the constants header is included by users of the offsets.
*/
package pcs_cfg_pkg;

	// Register access request from the management engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mgmt_req_s;

	// Decoded control fields
	typedef struct packed {
		logic true_quiet_tx_enable;
		logic signal_detect_force;
		logic signal_detect_algorithm_select;
		logic descrambler_timeout_select;
		logic force_100_link_good;
		logic nrzi_bypass;
	} pcs_ctrl_s;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_WRITE,
		ACC_READ
	} access_e;

endpackage

// ### hdl/desc_timeout_sel.sv
/*
 Picks the descrambler loss-of-lock timeout in clock cycles.
 Assumes a 100 MHz clock; output is registered.
*/
`timescale 1ns/1ps
`include "pcs_cfg_params.svh"

module desc_timeout_sel #(
	parameter int CNT_W = 18,
	parameter int LONG_CYCLES = `PCS_DESC_LONG_CYCLES,
	parameter int SHORT_CYCLES = `PCS_DESC_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Selection
	input wire logic long_sel_i,
	// Timeout count
	output logic [CNT_W-1:0] timeout_cycles_o
);

	logic [CNT_W-1:0] timeout_reg;
	logic [CNT_W-1:0] timeout_next;

	// ***********************
	// Timeout choice
	// ***********************
	always_comb begin
		if (long_sel_i) begin
			timeout_next = CNT_W'(LONG_CYCLES);
		end else begin
			timeout_next = CNT_W'(SHORT_CYCLES);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_reg <= CNT_W'(SHORT_CYCLES);
		end else begin
			timeout_reg <= timeout_next;
		end
	end

	assign timeout_cycles_o = timeout_reg;

endmodule

// ### hdl/pcs_100m_config_status_reg.sv
/*
 The 100 Mb/s PCS configuration and status register, reached through the
 management register port at address 0x16. It stores six control fields and
 drives them to the PCS and PMA as registered levels:
  bit 10 true_quiet_tx_enable, reset 0
  bit 9 signal_detect_force, reset 0
  bit 8 signal_detect_algorithm_select, reset 1
  bit 7 descrambler_timeout_select, reset 0
  bit 5 force_100_link_good, reset 0
  bit 2 nrzi_bypass, reset 0
 Bits 15 to 13 and the must-be-zero bits are never stored and read as zero.
 A read answers one cycle after it is taken, with a one-cycle valid pulse;
 the read data then holds until the next read.
 A write reaches the controls one cycle after it is taken and the descrambler
 timeout count one cycle after that.
 A write wins over a read presented in the same cycle.
 Requests to any other address are ignored.
 Every output comes straight from a flip-flop.

 Assumes the serial management engine presents decoded single-cycle read and
 write strobes on the management clock, and that software writes zero to the
 must-be-zero bits.
*/
`timescale 1ns/1ps
`include "pcs_cfg_params.svh"

module pcs_100m_config_status_reg #(
	parameter int CNT_W = 18,
	parameter int LONG_CYCLES = `PCS_DESC_LONG_CYCLES,
	parameter int SHORT_CYCLES = `PCS_DESC_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Management request
	input wire pcs_cfg_pkg::mgmt_req_s req_i,
	// Read response
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	// Controls to the PCS and PMA
	output pcs_cfg_pkg::pcs_ctrl_s ctrl_o,
	output logic [CNT_W-1:0] desc_timeout_cycles_o
);

	// ***********************
	// Field map
	// ***********************
	localparam logic [4:0] REG_ADDR = `PCS_CFG_ADDR;
	localparam logic [15:0] WR_MASK = `PCS_CFG_WRITE_MASK;
	localparam logic [15:0] HI_MASK = `PCS_CFG_RESERVED_HI_MASK;
	localparam logic [15:0] MZ_MASK = `PCS_CFG_MUST_ZERO_MASK;
	localparam logic [15:0] RD_MASK = ~(HI_MASK | MZ_MASK);
	localparam logic [15:0] CFG_RST = `PCS_CFG_RESET;
	localparam int unsigned BIT_TQ = `PCS_CFG_BIT_TRUE_QUIET;
	localparam int unsigned BIT_SDF = `PCS_CFG_BIT_SD_FORCE;
	localparam int unsigned BIT_SDA = `PCS_CFG_BIT_SD_ALGO;
	localparam int unsigned BIT_DT = `PCS_CFG_BIT_DESCRAMBLER_TIMEOUT_SELECT;
	localparam int unsigned BIT_FL = `PCS_CFG_BIT_FORCE_LINK;
	localparam int unsigned BIT_NB = `PCS_CFG_BIT_NRZI_BYPASS;

	// Control levels implied by the reset word
	localparam pcs_cfg_pkg::pcs_ctrl_s CTRL_RST = '{
		true_quiet_tx_enable: CFG_RST[BIT_TQ],
		signal_detect_force: CFG_RST[BIT_SDF],
		signal_detect_algorithm_select: CFG_RST[BIT_SDA],
		descrambler_timeout_select: CFG_RST[BIT_DT],
		force_100_link_good: CFG_RST[BIT_FL],
		nrzi_bypass: CFG_RST[BIT_NB]
	};

	// ***********************
	// Signals
	// ***********************
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [15:0] rd_word;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	pcs_cfg_pkg::pcs_ctrl_s ctrl_reg;
	pcs_cfg_pkg::pcs_ctrl_s ctrl_next;
	pcs_cfg_pkg::access_e acc;
	logic hit;
	logic wr_take;
	logic rd_take;

	// ***********************
	// Access decode
	// ***********************
	// Only the one address is answered
	always_comb begin
		hit = (req_i.addr == REG_ADDR);
		if (hit && req_i.wr) begin
			acc = pcs_cfg_pkg::ACC_WRITE;
		end else if (hit && req_i.rd) begin
			acc = pcs_cfg_pkg::ACC_READ;
		end else begin
			acc = pcs_cfg_pkg::ACC_IDLE;
		end
	end

	// Write wins when both strobes arrive together
	always_comb begin
		wr_take = 1'b0;
		rd_take = 1'b0;
		case (acc)
			pcs_cfg_pkg::ACC_WRITE: begin
				wr_take = 1'b1;
			end
			pcs_cfg_pkg::ACC_READ: begin
				rd_take = 1'b1;
			end
			default: begin
				wr_take = 1'b0;
				rd_take = 1'b0;
			end
		endcase
	end

	// ***********************
	// Stored and read bits
	// ***********************
	for (genvar b = 0; b < 16; b++) begin : g_bit
		if (WR_MASK[b]) begin : g_rw
			// Field bit takes the written value
			assign cfg_next[b] = wr_take ? req_i.wdata[b] : cfg_reg[b];
		end else begin : g_fixed
			// Write dropped, bit held at zero
			assign cfg_next[b] = 1'b0;
		end
		// Read view masks reserved bits
		if (RD_MASK[b]) begin : g_live
			assign rd_word[b] = cfg_reg[b];
		end else begin : g_zero
			// Reads as zero whatever is stored
			assign rd_word[b] = 1'b0;
		end
	end

	// Bit 8 set, other fields clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= CFG_RST;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// ***********************
	// Read path
	// ***********************
	// Data holds until the next read
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (rd_take) begin
			rdata_next = rd_word;
			rvalid_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ***********************
	// Control fan-out
	// ***********************
	// Controls change in step with the register
	always_comb begin
		ctrl_next.true_quiet_tx_enable = cfg_next[BIT_TQ];
		ctrl_next.signal_detect_force = cfg_next[BIT_SDF];
		ctrl_next.signal_detect_algorithm_select = cfg_next[BIT_SDA];
		ctrl_next.descrambler_timeout_select = cfg_next[BIT_DT];
		ctrl_next.force_100_link_good = cfg_next[BIT_FL];
		ctrl_next.nrzi_bypass = cfg_next[BIT_NB];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ***********************
	// Descrambler timeout
	// ***********************
	desc_timeout_sel #(
		.CNT_W(CNT_W),
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES)
	) u_desc_timeout (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.long_sel_i(ctrl_reg.descrambler_timeout_select),
		.timeout_cycles_o(desc_timeout_cycles_o)
	);

	// ***********************
	// Outputs
	// ***********************
	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign ctrl_o = ctrl_reg;

endmodule

// ### test/pcs_cfg_properties.sv
/* Port checker for the PCS config register.
 Assumes one clock, synchronous high reset, bound below. */
`timescale 1ns/1ps
module pcs_cfg_properties #(
	parameter int CNT_W = 18,
	parameter int LONG_CYCLES = 200000,
	parameter int SHORT_CYCLES = 72200
) (
	// Watched ports
	input logic clk_i,
	input logic rst_i,
	input pcs_cfg_pkg::mgmt_req_s req_i,
	input logic [15:0] rdata_o,
	input logic rvalid_o,
	input pcs_cfg_pkg::pcs_ctrl_s ctrl_o,
	input logic [CNT_W-1:0] desc_timeout_cycles_o
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr_hit;
	assign wr_hit = req_i.wr && req_i.addr == 5'h16;
	sequence s_wr;
		wr_hit ##1 1'b1;
	endsequence
	a_fixed_zero: assert property (rvalid_o |-> (rdata_o & 16'hF85B) == 16'h0000)
		else $error("reserved bits read nonzero");
	a_quiet_wr: assert property (wr_hit |=> ctrl_o.true_quiet_tx_enable == $past(req_i.wdata[10]))
		else $error("quiet enable wrong");
	a_force_wr: assert property (wr_hit |=> ctrl_o.signal_detect_force == $past(req_i.wdata[9]))
		else $error("detect force wrong");
	a_algo_wr: assert property (wr_hit |=> ctrl_o.signal_detect_algorithm_select == $past(req_i.wdata[8]))
		else $error("algorithm select wrong");
	a_reset_vals: assert property ($fell(rst_i) |-> ctrl_o == 6'h08)
		else $error("reset controls wrong");
	a_timeout_sel: assert property (s_wr |=> desc_timeout_cycles_o ==
		($past(req_i.wdata[7], 2) ? LONG_CYCLES : SHORT_CYCLES))
		else $error("timeout count wrong");
	a_link_wr: assert property (wr_hit |=> ctrl_o.force_100_link_good == $past(req_i.wdata[5]))
		else $error("link force wrong");
	a_nrzi_wr: assert property (wr_hit |=> ctrl_o.nrzi_bypass == $past(req_i.wdata[2]))
		else $error("bypass wrong");
endmodule
bind pcs_100m_config_status_reg pcs_cfg_properties #(.CNT_W(CNT_W), .LONG_CYCLES(LONG_CYCLES),
	.SHORT_CYCLES(SHORT_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
	.rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .desc_timeout_cycles_o(desc_timeout_cycles_o));

// ### test/pcs_100m_config_status_reg_bench.sv
/* Bench for the PCS config register.
 Assumes design and checker compile first. */
`timescale 1ns/1ps
module pcs_100m_config_status_reg_bench;
	logic clk_i = 0;
	logic rst_i = 1;
	pcs_cfg_pkg::mgmt_req_s req_i = '0;
	logic [15:0] rdata_o;
	logic rvalid_o;
	pcs_cfg_pkg::pcs_ctrl_s ctrl_o;
	logic [17:0] desc_timeout_cycles_o;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [15:0] m = 16'h0100;
	logic [31:0] x = 32'h87130AA1;
	always #5 clk_i = ~clk_i;
	pcs_100m_config_status_reg dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .desc_timeout_cycles_o(desc_timeout_cycles_o));
	// ****
	// Tasks
	// ****
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req_i <= '{w, !w, a, d};
		@(posedge clk_i);
		req_i <= '0;
		#1;
	endtask
	task finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			finish_test;
		end
	end
	initial begin
		logic [4:0] a;
		logic [15:0] v;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 40; i++) begin
			if (i == 20) begin
				@(posedge clk_i);
				rst_i <= 1;
				repeat (2) @(posedge clk_i);
				rst_i <= 0;
				m = 16'h0100;
			end
			acc(0, 5'h16, 16'h0000);
			chk(rvalid_o, 1);
			chk(rdata_o, m);
			chk(ctrl_o, {m[10], m[9], m[8], m[7], m[5], m[2]});
			chk(desc_timeout_cycles_o, m[7] ? 18'h30D40 : 18'h11A08);
			x = xs(x);
			a = (i < 2 || x[31]) ? 5'h16 : x[20:16];
			v = (i == 0) ? 16'hFFFF : ((i == 1) ? 16'h0000 : x[15:0]);
			v = v & 16'hE7A4;
			acc(1, a, v);
			if (a == 5'h16)
				m = v & 16'h07A4;
		end
		finish_test;
	end
endmodule
